/* utr_pkg.sv */
// constants and helpers for the serial transmit and receive path
`default_nettype none
package utr_pkg;
	// register byte offsets on the apb bus
	localparam logic [11:0] OFF_DATA = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_CTRL_B = 12'h008;
	localparam logic [11:0] OFF_CTRL_C = 12'h00C;
	localparam logic [11:0] OFF_BAUD = 12'h010;
	// status register bit positions
	localparam int ST_RXC = 7;
	localparam int ST_TXC = 6;
	localparam int ST_BUFFER_EMPTY_FLAG = 5;
	localparam int ST_U2X = 1;
	// control register b bit positions
	localparam int CB_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
	localparam int CB_BUFFER_EMPTY_IRQ_ENABLE = 5;
	localparam int CB_RECEIVER_ENABLE = 4;
	localparam int CB_TRANSMITTER_ENABLE = 3;
	localparam int CB_SZ2 = 2;
	localparam int CB_RXB8 = 1;
	localparam int CB_NINTH_TRANSMIT_BIT = 0;
	// control register c bit positions
	localparam int CC_SYNC = 6;
	localparam int CC_PAR_EN = 5;
	localparam int CC_PAR_ODD = 4;
	localparam int CC_STOP2 = 3;
	localparam int CC_SZ1 = 2;
	localparam int CC_SZ0 = 1;
	localparam int CC_POL = 0;
	// reset values and the nine-bit size code
	localparam logic [2:0] SIZE_RESET = 3'h3;
	localparam logic [11:0] BAUD_RESET = 12'h000;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	// oversampling: last sample index per bit, normal and double speed
	localparam logic [3:0] OS_LAST_NORM = 4'hF;
	localparam logic [3:0] OS_LAST_FAST = 4'h7;
	// data bits for a character size code
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		unique case (code)
			3'h0: char_bits = 4'h5;
			3'h1: char_bits = 4'h6;
			3'h2: char_bits = 4'h7;
			SIZE_NINE: char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction
	// keep only the low n bits of a character
	function automatic logic [8:0] mask_char(input logic [8:0] d,
		input logic [3:0] n);
		mask_char = 9'h000;
		for (int i = 0; i < 9; i++)
			mask_char[i] = d[i] & (4'(i) < n);
	endfunction
	// parity over the low n bits
	function automatic logic parity(input logic [8:0] d,
		input logic [3:0] n, input logic odd);
		parity = (^mask_char(d, n)) ^ odd;
	endfunction
endpackage
`default_nettype wire

/* utr_usart_path.sv */
// serial transmitter and receiver front with apb register access
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module utr_usart_path
	import utr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic global_irq_enable,
	input wire logic tx_complete_irq_ack,
	input wire logic rxd_pin,
	input wire logic sync_clock_pin,
	output logic txd_pin_out,
	output logic txd_override,
	output logic rxd_override,
	output logic sync_clock_override,
	output logic buffer_empty_irq,
	output logic transmit_complete_irq
);
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} utr_tx_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} utr_rx_e;

	// bus and register state
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic transmit_complete_irq_enable_q, transmit_complete_irq_enable_d; // transmit-complete interrupt enable
	logic buffer_empty_irq_enable_q, buffer_empty_irq_enable_d; // buffer-empty interrupt enable
	logic receiver_enable_q, receiver_enable_d; // receiver_enable
	logic transmitter_enable_q, transmitter_enable_d; // transmitter_enable as written
	logic [2:0] csize_q, csize_d; // character_size code
	logic ninth_transmit_bit_q, ninth_transmit_bit_d; // ninth_transmit_bit
	logic sync_q, sync_d; // synchronous mode
	logic par_en_q, par_en_d; // parity_enable_bit
	logic par_odd_q, par_odd_d; // parity_odd_select
	logic stop2_q, stop2_d; // two stop bits on transmit
	logic pol_q, pol_d; // sync clock polarity
	logic dspeed_q, dspeed_d; // double_speed
	logic [11:0] baud_q, baud_d;
	// shared timing state
	logic [11:0] pre_q, pre_d;
	logic rxd_s1_q, rxd_s2_q;
	logic sck_s1_q, sck_s2_q, sck_s3_q;
	// transmit state
	utr_tx_e tx_st_q, tx_st_d;
	logic [8:0] tx_buf_q, tx_buf_d;
	logic tx_full_q, tx_full_d;
	logic [8:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_idx_q, tx_idx_d;
	logic [3:0] tx_os_q, tx_os_d;
	logic tx_par_q, tx_par_d;
	logic txd_q, txd_d;
	logic txc_q, txc_d; // transmit_complete_flag
	logic txon_q, txon_d; // transmitter really active
	// receive state
	utr_rx_e rx_st_q, rx_st_d;
	logic [8:0] rx_sh_q, rx_sh_d;
	logic [3:0] rx_idx_q, rx_idx_d;
	logic [3:0] rx_os_q, rx_os_d;
	logic [8:0] rx_buf_q, rx_buf_d;
	logic rxc_q, rxc_d; // receive_complete_flag
	// registered pin and interrupt outputs
	logic txo_q, rxo_q, scko_q, beirq_q, tcirq_q;

	// decoded bus strobes and helpers
	logic acc, wr_en, rd_en, tick, rise, fall, chg_edge, smp_edge;
	logic tx_step, rx_samp, tx_load;
	logic [3:0] nbits, os_last;

	assign acc = psel & penable & pready_q;
	assign wr_en = acc & pwrite;
	assign rd_en = acc & ~pwrite;
	assign nbits = char_bits(csize_q);
	// double speed halves samples per bit, async only
	assign os_last = (dspeed_q & ~sync_q) ? OS_LAST_FAST : OS_LAST_NORM;
	assign tick = (pre_q == 12'h000);
	assign rise = sck_s2_q & ~sck_s3_q;
	assign fall = ~sck_s2_q & sck_s3_q;
	// data changes on one sync clock edge and is sampled on the other
	assign chg_edge = pol_q ? fall : rise;
	assign smp_edge = pol_q ? rise : fall;
	assign tx_step = sync_q ? chg_edge : (tick & (tx_os_q == os_last));
	assign rx_samp = sync_q ? smp_edge : (tick & (rx_os_q == os_last));

	// apb decode, register writes and read data
	always_comb
	begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		transmit_complete_irq_enable_d = transmit_complete_irq_enable_q;
		buffer_empty_irq_enable_d = buffer_empty_irq_enable_q;
		receiver_enable_d = receiver_enable_q;
		transmitter_enable_d = transmitter_enable_q;
		csize_d = csize_q;
		ninth_transmit_bit_d = ninth_transmit_bit_q;
		sync_d = sync_q;
		par_en_d = par_en_q;
		par_odd_d = par_odd_q;
		stop2_d = stop2_q;
		pol_d = pol_q;
		dspeed_d = dspeed_q;
		baud_d = baud_q;
		// answer is prepared in the first access cycle
		if (psel & penable & ~pready_q)
		begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				OFF_DATA: prdata_d[7:0] = rx_buf_q[7:0];
				OFF_STATUS:
				begin
					prdata_d[ST_RXC] = rxc_q;
					prdata_d[ST_TXC] = txc_q;
					prdata_d[ST_BUFFER_EMPTY_FLAG] = ~tx_full_q;
					prdata_d[ST_U2X] = dspeed_q;
				end
				OFF_CTRL_B:
				begin
					prdata_d[CB_TRANSMIT_COMPLETE_IRQ_ENABLE] = transmit_complete_irq_enable_q;
					prdata_d[CB_BUFFER_EMPTY_IRQ_ENABLE] = buffer_empty_irq_enable_q;
					prdata_d[CB_RECEIVER_ENABLE] = receiver_enable_q;
					prdata_d[CB_TRANSMITTER_ENABLE] = transmitter_enable_q;
					prdata_d[CB_SZ2] = csize_q[2];
					prdata_d[CB_RXB8] = rx_buf_q[8];
					prdata_d[CB_NINTH_TRANSMIT_BIT] = ninth_transmit_bit_q;
				end
				OFF_CTRL_C:
				begin
					prdata_d[CC_SYNC] = sync_q;
					prdata_d[CC_PAR_EN] = par_en_q;
					prdata_d[CC_PAR_ODD] = par_odd_q;
					prdata_d[CC_STOP2] = stop2_q;
					prdata_d[CC_SZ1] = csize_q[1];
					prdata_d[CC_SZ0] = csize_q[0];
					prdata_d[CC_POL] = pol_q;
				end
				OFF_BAUD: prdata_d[11:0] = baud_q;
				// unmapped address answers with an error
				default: pslverr_d = 1'b1;
			endcase
		end
		// register writes take effect on the completing edge
		if (wr_en)
		begin
			unique case (paddr)
				OFF_STATUS: dspeed_d = pwdata[ST_U2X];
				OFF_CTRL_B:
				begin
					transmit_complete_irq_enable_d = pwdata[CB_TRANSMIT_COMPLETE_IRQ_ENABLE];
					buffer_empty_irq_enable_d = pwdata[CB_BUFFER_EMPTY_IRQ_ENABLE];
					receiver_enable_d = pwdata[CB_RECEIVER_ENABLE];
					transmitter_enable_d = pwdata[CB_TRANSMITTER_ENABLE];
					csize_d[2] = pwdata[CB_SZ2];
					ninth_transmit_bit_d = pwdata[CB_NINTH_TRANSMIT_BIT];
				end
				OFF_CTRL_C:
				begin
					sync_d = pwdata[CC_SYNC];
					par_en_d = pwdata[CC_PAR_EN];
					par_odd_d = pwdata[CC_PAR_ODD];
					stop2_d = pwdata[CC_STOP2];
					csize_d[1:0] = pwdata[CC_SZ1:CC_SZ0];
					pol_d = pwdata[CC_POL];
				end
				OFF_BAUD: baud_d = pwdata[11:0];
				// data writes are handled by the transmit group
				default: baud_d = baud_q;
			endcase
		end
	end

	// register the bus and configuration state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			transmit_complete_irq_enable_q <= 1'b0;
			buffer_empty_irq_enable_q <= 1'b0;
			receiver_enable_q <= 1'b0;
			transmitter_enable_q <= 1'b0;
			csize_q <= SIZE_RESET;
			ninth_transmit_bit_q <= 1'b0;
			sync_q <= 1'b0;
			par_en_q <= 1'b0;
			par_odd_q <= 1'b0;
			stop2_q <= 1'b0;
			pol_q <= 1'b0;
			dspeed_q <= 1'b0;
			baud_q <= BAUD_RESET;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			transmit_complete_irq_enable_q <= transmit_complete_irq_enable_d;
			buffer_empty_irq_enable_q <= buffer_empty_irq_enable_d;
			receiver_enable_q <= receiver_enable_d;
			transmitter_enable_q <= transmitter_enable_d;
			csize_q <= csize_d;
			ninth_transmit_bit_q <= ninth_transmit_bit_d;
			sync_q <= sync_d;
			par_en_q <= par_en_d;
			par_odd_q <= par_odd_d;
			stop2_q <= stop2_d;
			pol_q <= pol_d;
			dspeed_q <= dspeed_d;
			baud_q <= baud_d;
		end
	end

	// sample-rate prescaler: one tick every baud+1 clocks
	always_comb
	begin
		pre_d = tick ? baud_q : pre_q - 12'h001;
	end

	// prescaler, pin synchronisers and registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_q <= 12'h000;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			txo_q <= 1'b0;
			rxo_q <= 1'b0;
			scko_q <= 1'b0;
			beirq_q <= 1'b0;
			tcirq_q <= 1'b0;
		end
		else
		begin
			pre_q <= pre_d;
			rxd_s1_q <= rxd_pin;
			rxd_s2_q <= rxd_s1_q;
			sck_s1_q <= sync_clock_pin;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			txo_q <= txon_d;
			rxo_q <= receiver_enable_d;
			scko_q <= sync_d & (txon_d | receiver_enable_d);
			// level request while buffer empty
			beirq_q <= buffer_empty_irq_enable_d & global_irq_enable & ~tx_full_d;
			tcirq_q <= transmit_complete_irq_enable_d & global_irq_enable & txc_d;
		end
	end

	// transmit path: buffer, shifter and frame sequencer
	always_comb
	begin
		tx_st_d = tx_st_q;
		tx_buf_d = tx_buf_q;
		tx_full_d = tx_full_q;
		tx_sh_d = tx_sh_q;
		tx_idx_d = tx_idx_q;
		tx_par_d = tx_par_q;
		txc_d = txc_q;
		txon_d = txon_q;
		tx_os_d = (tx_st_q == TX_IDLE || tx_step) ? 4'h0 :
			(tick ? tx_os_q + 4'h1 : tx_os_q);
		tx_load = 1'b0;
		unique case (tx_st_q)
			TX_IDLE:
				tx_load = txon_q & tx_full_q;
			TX_START:
				if (tx_step)
				begin
					tx_st_d = TX_DATA;
					tx_idx_d = 4'h0;
				end
			TX_DATA:
				if (tx_step)
				begin
					if (tx_idx_q == nbits - 4'h1)
					begin
						tx_idx_d = 4'h0;
						tx_st_d = par_en_q ? TX_PAR : TX_STOP;
					end
					else
						tx_idx_d = tx_idx_q + 4'h1;
				end
			TX_PAR:
				if (tx_step)
					tx_st_d = TX_STOP;
			TX_STOP:
				if (tx_step)
				begin
					if (stop2_q && tx_idx_q == 4'h0)
						tx_idx_d = 4'h1;
					else
					begin
						// last stop bit: reload at once or go idle
						tx_st_d = TX_IDLE;
						tx_load = tx_full_q;
						txc_d = ~tx_full_q;
					end
				end
		endcase
		// move buffered character into the shifter
		if (tx_load)
		begin
			tx_sh_d = tx_buf_q;
			tx_par_d = parity(tx_buf_q, nbits, par_odd_q);
			tx_full_d = 1'b0;
			tx_st_d = TX_START;
			tx_idx_d = 4'h0;
		end
		// a data write loads the buffer; it wins over the move
		if (wr_en && paddr == OFF_DATA)
		begin
			tx_buf_d = mask_char({ninth_transmit_bit_q, pwdata[7:0]}, nbits);
			tx_full_d = 1'b1;
		end
		// flag cleared by service or a one-write; a new set wins
		if ((tx_complete_irq_ack ||
			(wr_en && paddr == OFF_STATUS && pwdata[ST_TXC])) &&
			!(tx_st_q == TX_STOP && tx_st_d == TX_IDLE && !tx_full_q))
			txc_d = 1'b0;
		// enable at once, disable only once nothing is left to send
		if (transmitter_enable_q)
			txon_d = 1'b1;
		else if (tx_st_d == TX_IDLE && !tx_full_d)
			txon_d = 1'b0;
		// line level follows the next state
		unique case (tx_st_d)
			TX_START: txd_d = 1'b0;
			TX_DATA: txd_d = tx_sh_d[tx_idx_d];
			TX_PAR: txd_d = tx_par_d;
			default: txd_d = 1'b1;
		endcase
	end

	// register the transmit state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st_q <= TX_IDLE;
			tx_buf_q <= 9'h000;
			tx_full_q <= 1'b0;
			tx_sh_q <= 9'h000;
			tx_idx_q <= 4'h0;
			tx_os_q <= 4'h0;
			tx_par_q <= 1'b0;
			txd_q <= 1'b1;
			txc_q <= 1'b0;
			txon_q <= 1'b0;
		end
		else
		begin
			tx_st_q <= tx_st_d;
			tx_buf_q <= tx_buf_d;
			tx_full_q <= tx_full_d;
			tx_sh_q <= tx_sh_d;
			tx_idx_q <= tx_idx_d;
			tx_os_q <= tx_os_d;
			tx_par_q <= tx_par_d;
			txd_q <= txd_d;
			txc_q <= txc_d;
			txon_q <= txon_d;
		end
	end

	// receive path: start detection, shifting and buffer move
	always_comb
	begin
		rx_st_d = rx_st_q;
		rx_sh_d = rx_sh_q;
		rx_idx_d = rx_idx_q;
		rx_buf_d = rx_buf_q;
		rxc_d = rxc_q;
		rx_os_d = (rx_st_q == RX_IDLE || rx_samp) ? 4'h0 :
			(tick ? rx_os_q + 4'h1 : rx_os_q);
		// reading data empties the buffer
		if (rd_en && paddr == OFF_DATA)
			rxc_d = 1'b0;
		unique case (rx_st_q)
			RX_IDLE:
				if (!rxd_s2_q)
				begin
					rx_sh_d = 9'h000;
					rx_idx_d = 4'h0;
					// sync mode needs only a low at the sample edge
					if (!sync_q)
						rx_st_d = RX_START;
					else if (smp_edge)
						rx_st_d = RX_DATA;
				end
			RX_START:
				// recheck the line at mid start bit
				if (tick && rx_os_q == (os_last >> 1))
				begin
					rx_st_d = rxd_s2_q ? RX_IDLE : RX_DATA;
					rx_os_d = 4'h0;
				end
			RX_DATA:
				if (rx_samp)
				begin
					rx_sh_d[rx_idx_q] = rxd_s2_q;
					if (rx_idx_q == nbits - 4'h1)
						rx_st_d = par_en_q ? RX_PAR : RX_STOP;
					else
						rx_idx_d = rx_idx_q + 4'h1;
				end
			RX_PAR:
				if (rx_samp)
					rx_st_d = RX_STOP;
			RX_STOP:
				// first stop ends the frame, a second is not waited for
				if (rx_samp)
				begin
					rx_buf_d = rx_sh_q;
					rxc_d = 1'b1;
					rx_st_d = RX_IDLE;
				end
		endcase
		// receiver off drops any frame and flushes the buffer
		if (!receiver_enable_q)
		begin
			rx_st_d = RX_IDLE;
			rxc_d = 1'b0;
		end
	end

	// register the receive state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st_q <= RX_IDLE;
			rx_sh_q <= 9'h000;
			rx_idx_q <= 4'h0;
			rx_os_q <= 4'h0;
			rx_buf_q <= 9'h000;
			rxc_q <= 1'b0;
		end
		else
		begin
			rx_st_q <= rx_st_d;
			rx_sh_q <= rx_sh_d;
			rx_idx_q <= rx_idx_d;
			rx_os_q <= rx_os_d;
			rx_buf_q <= rx_buf_d;
			rxc_q <= rxc_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txd_pin_out = txd_q;
	assign txd_override = txo_q;
	assign rxd_override = rxo_q;
	assign sync_clock_override = scko_q;
	assign buffer_empty_irq = beirq_q;
	assign transmit_complete_irq = tcirq_q;
endmodule
`default_nettype wire

/* utr_sva.sv */
// concurrent checks on the serial path ports
`timescale 1ns/1ns
`default_nettype none
module utr_sva
	import utr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic global_irq_enable,
	input wire logic tx_complete_irq_ack,
	input wire logic txd_pin_out,
	input wire logic txd_override,
	input wire logic rxd_override,
	input wire logic sync_clock_override,
	input wire logic buffer_empty_irq,
	input wire logic transmit_complete_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// one wait state, then a one-cycle answer
	sequence s_wait;
		!pready ##1 pready;
	endsequence
	// start bit lasts at least the short bit time
	sequence s_start;
		(!txd_pin_out)[*8];
	endsequence
	a_apb_wait:
	assert property (psel && $rose(penable) |-> s_wait ##1 !pready)
		else $error("apb answer timing wrong");
	a_start_low:
	assert property ($fell(txd_pin_out) |-> txd_override ##0 s_start)
		else $error("start bit too short");
	a_idle_high:
	assert property (!txd_override |-> txd_pin_out)
		else $error("released line not high");
	a_release_stop:
	assert property ($fell(txd_override) |-> txd_pin_out && $past(txd_pin_out))
		else $error("pin released mid frame");
	a_be_gate:
	assert property (buffer_empty_irq |-> $past(global_irq_enable))
		else $error("buffer empty request without enable");
	a_tc_gate:
	assert property (transmit_complete_irq |-> $past(global_irq_enable))
		else $error("complete request without enable");
	a_tc_line:
	assert property ($rose(transmit_complete_irq) |-> txd_pin_out)
		else $error("complete raised while line busy");
	a_ack_clear:
	assert property (tx_complete_irq_ack |-> ##2 !transmit_complete_irq)
		else $error("service did not clear complete");
	a_sync_owner:
	assert property (sync_clock_override |-> txd_override || rxd_override)
		else $error("clock pin taken while idle");
endmodule
bind utr_usart_path utr_sva i_utr_sva (.pclk, .presetn, .psel, .penable,
	.pready, .global_irq_enable, .tx_complete_irq_ack, .txd_pin_out,
	.txd_override, .rxd_override, .sync_clock_override, .buffer_empty_irq,
	.transmit_complete_irq);
`default_nettype wire

/* utr_peer.sv */
// remote serial transceiver facing the transmit and receive lines
`timescale 1ns/1ns
`default_nettype none
module utr_peer
(
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	int bt = 16; // clocks per bit
	int nb = 9; // bits taken after the start bit
	logic [10:0] q[$]; // captured frames, unused bits high
	logic [10:0] f; // frame being captured
	// sample each incoming frame at mid-bit
	initial
	begin
		forever
		begin
			@(negedge txd);
			repeat (bt / 2) @(posedge clk);
			// a glitch shorter than half a bit is not a start
			if (txd === 1'b0)
			begin
				f = '1;
				for (int i = 0; i < nb; i++)
				begin
					repeat (bt) @(posedge clk);
					f[i] = txd;
				end
				q.push_back(f);
			end
		end
	end
	// idle line rests high
	initial rxd = 1'b1;
	// start low, data lsb first, then two stop bits
	task automatic send(input logic [8:0] d, input int n);
		@(posedge clk);
		rxd <= 1'b0;
		for (int i = 0; i < n + 2; i++)
		begin
			repeat (bt) @(posedge clk);
			rxd <= (i < n) ? d[i] : 1'b1;
		end
		repeat (bt) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* test_usart_transmit_receive_path.sv */
// self-checking bench for the serial transmit and receive path
`timescale 1ns/1ns
`default_nettype none
module test_usart_transmit_receive_path
	import utr_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, gie, ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, rerr, rxd, txd, txo, rxo, sco, beirq, tcirq;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	// device under test, sync clock pin tied low
	utr_usart_path i_utr_usart_path (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .global_irq_enable(gie),
		.tx_complete_irq_ack(ack), .rxd_pin(rxd), .sync_clock_pin(1'b0),
		.txd_pin_out(txd), .txd_override(txo), .rxd_override(rxo),
		.sync_clock_override(sco), .buffer_empty_irq(beirq),
		.transmit_complete_irq(tcirq));
	utr_peer i_utr_peer (.clk(pclk), .txd(txd), .rxd(rxd));
	// clock of 50 ns period
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checked %0d, failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		// at each edge pready is seen as sampled, before it updates
		do @(posedge pclk);
		while (pready !== 1'b1);
		// read data taken and request released at the completing edge
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read status until a flag is up
	task automatic poll(input int b);
		do apb(1'b0, OFF_STATUS, 32'h0);
		while (rdat[b] !== 1'b1);
	endtask
	// expected frame after the start bit, unused bits high
	function automatic logic [10:0] frm(input logic [8:0] d, input int n,
		input logic pe, input logic od);
		logic [10:0] x;
		logic p;
		x = '1;
		p = od;
		for (int i = 0; i < n; i++)
		begin
			x[i] = d[i];
			p ^= d[i];
		end
		if (pe)
			x[n] = p;
		return x;
	endfunction
	// main sequence
	initial
	begin
		logic [8:0] d;
		logic [2:0] sz;
		logic pe, od, ds;
		int n;
		{presetn, psel, penable, pwrite, gie, ack} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(32'h0E74));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// reset state and an unmapped address
		@(negedge pclk);
		chk(txo, 1'b0);
		chk(txd, 1'b1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat, 32'h20);
		apb(1'b0, OFF_CTRL_C, 32'h0);
		chk(rdat, 32'h6);
		apb(1'b0, 12'h014, 32'h0);
		chk(rerr, 1'b1);
		apb(1'b1, OFF_BAUD, 32'h0);
		$display("reset test done");
		// every size, random parity, both speeds
		for (int i = 0; i < 5; i++)
		begin
			sz = (i == 4) ? SIZE_NINE : 3'(i);
			n = (i == 4) ? 9 : i + 5;
			d = 9'($urandom);
			pe = 1'($urandom);
			od = 1'($urandom);
			ds = i[0];
			i_utr_peer.bt = ds ? 8 : 16;
			i_utr_peer.nb = n + pe + 1;
			apb(1'b1, OFF_STATUS, {30'h0, ds, 1'b0});
			apb(1'b1, OFF_CTRL_C, {26'h0, pe, od, 1'b0, sz[1:0], 1'b0});
			apb(1'b1, OFF_CTRL_B, {29'h3, sz[2], 1'b0, d[8]});
			apb(1'b1, OFF_DATA, {23'($urandom), d});
			while (i_utr_peer.q.size() == 0) @(posedge pclk);
			chk(i_utr_peer.q.pop_front(), frm(d, n, pe, od));
			poll(ST_TXC);
			apb(1'b1, OFF_STATUS, {26'h1, 4'h0, ds, 1'b0});
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rdat[ST_TXC], 1'b0);
		end
		$display("frame format test done");
		// back to back words with two stop bits, then a deferred disable
		i_utr_peer.bt = 16;
		i_utr_peer.nb = 10;
		apb(1'b1, OFF_STATUS, 32'h0);
		apb(1'b1, OFF_CTRL_C, 32'hE);
		apb(1'b1, OFF_CTRL_B, 32'h18);
		d = 9'($urandom);
		sz = 3'($urandom);
		apb(1'b1, OFF_DATA, {23'h0, d});
		apb(1'b1, OFF_DATA, {29'h0, sz});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[ST_BUFFER_EMPTY_FLAG], 1'b0);
		apb(1'b1, OFF_CTRL_B, 32'h10);
		chk(txo, 1'b1);
		while (i_utr_peer.q.size() < 2) @(posedge pclk);
		chk(i_utr_peer.q.pop_front(), frm(d, 8, 1'b0, 1'b0));
		chk(i_utr_peer.q.pop_front(), frm({6'h0, sz}, 8, 1'b0, 1'b0));
		poll(ST_TXC);
		@(negedge pclk);
		chk(txo, 1'b0);
		chk(rxo, 1'b1);
		apb(1'b1, OFF_STATUS, 32'h40);
		$display("disable test done");
		// five-bit reception, two stop bits sent
		apb(1'b1, OFF_CTRL_B, 32'h18);
		apb(1'b1, OFF_CTRL_C, 32'h0);
		repeat (2)
		begin
			d = 9'($urandom);
			i_utr_peer.send(d, 5);
			poll(ST_RXC);
			apb(1'b0, OFF_DATA, 32'h0);
			chk(rdat, {27'h0, d[4:0]});
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rdat[ST_RXC], 1'b0);
		end
		$display("receive test done");
		// interrupt requests, gating and service
		apb(1'b1, OFF_CTRL_C, 32'h6);
		apb(1'b1, OFF_CTRL_B, 32'h78);
		gie <= 1'b1;
		repeat (3) @(negedge pclk);
		chk(beirq, 1'b1);
		chk(tcirq, 1'b0);
		@(posedge pclk);
		gie <= 1'b0;
		repeat (3) @(negedge pclk);
		chk(beirq, 1'b0);
		@(posedge pclk);
		gie <= 1'b1;
		apb(1'b1, OFF_DATA, 32'hA5);
		while (i_utr_peer.q.size() == 0) @(posedge pclk);
		chk(i_utr_peer.q.pop_front(), frm(9'h0A5, 8, 1'b0, 1'b0));
		// request must follow the flag, seen through a status read
		poll(ST_TXC);
		@(negedge pclk);
		chk(tcirq, 1'b1);
		@(posedge pclk);
		ack <= 1'b1;
		@(posedge pclk);
		ack <= 1'b0;
		repeat (2) @(negedge pclk);
		chk(tcirq, 1'b0);
		apb(1'b1, OFF_CTRL_C, 32'h46);
		repeat (2) @(negedge pclk);
		chk(sco, 1'b1);
		apb(1'b1, OFF_CTRL_C, 32'h6);
		$display("interrupt test done");
		// reset in mid run returns control state to reset values
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(txo, 1'b0);
		chk(rxo, 1'b0);
		chk(beirq, 1'b0);
		apb(1'b0, OFF_CTRL_B, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat, 32'h20);
		$display("second reset test done");
		finish_test();
	end
endmodule
`default_nettype wire
